// *** src/ifd_decoder.sv ***
`timescale 1ns/1ns

// Summary of operation
// - A one-word instruction arrives as a single 24-bit word and is fully decoded from it.
// - An 8-bit opcode selects the type and the other bits are operand fields laid out by that type.
// - Exactly three opcodes take two words, and their result waits for the second word.
// - Every instruction falls in one of five classes: word/byte, bit, literal, DSP or control.
// - Register word/byte ops yield a plain base register, a source with modifier and a destination with modifier.
// - File register ops yield a file address and a select sending the result to that file or to register zero.
// - Bit ops yield a register or file target and a bit position from a literal or from the base register.
// - Literal moves yield the literal and its target, a base register or a file address.
// - Literal arithmetic takes the base register and the literal, with a destination only when it differs.
// - Multiply-accumulate ops always yield an accumulator, the two multiplier registers, prefetches and write-back.
// - Other DSP ops yield an accumulator, a source or destination with modifier and an optional shift amount.
// - A second word has a zero upper byte and on its own decodes as a no-operation.
module ifd_decoder import ifd_pkg::*; #(
	parameter logic [7:0] TWO_WORD_A = TW_OPC0,
	parameter logic [7:0] TWO_WORD_B = TW_OPC1,
	parameter logic [7:0] TWO_WORD_C = TW_OPC2
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [WORD_W-1:0] instr_word,
	input  wire logic              word_valid,
	output logic                   word_ready,
	output ifd_dec_t               dec_out,
	output logic                   dec_valid,
	input  wire logic              dec_ready
);

	typedef enum logic {ST_FIRST, ST_SECOND} ifd_state_t;

	ifd_state_t      state_reg;
	ifd_state_t      state_next;
	ifd_dec_t        pend_reg;
	ifd_dec_t        pend_next;
	ifd_dec_t        out_reg;
	ifd_dec_t        out_next;
	logic            valid_reg;
	logic            valid_next;
	ifd_dec_t        dec_first;
	ifd_class_t      cls_w;
	ifd_fmt_t        fmt_w;
	logic            two_word_w;
	logic [7:0]      opcode;
	logic [OPR_W-1:0] opr;
	logic            accept;

	assign opcode = instr_word[OPC_MSB:OPC_LSB];
	assign opr = instr_word[OPR_W-1:0];

	// ****************************************************************
	// Opcode classification
	// ****************************************************************
	ifd_classify #(
		.TWO_WORD_A (TWO_WORD_A),
		.TWO_WORD_B (TWO_WORD_B),
		.TWO_WORD_C (TWO_WORD_C)
	) u_classify (
		.opcode   (opcode),
		.cls      (cls_w),
		.fmt      (fmt_w),
		.two_word (two_word_w)
	);

	// ****************************************************************
	// Operand field extraction
	// ****************************************************************
	// Fields not used by a layout stay zero so the datapath sees no junk
	always_comb begin
		dec_first = '0;
		dec_first.cls = cls_w;
		dec_first.fmt = fmt_w;
		dec_first.two_word = two_word_w;
		case (fmt_w)
			FMT_WREG3: begin
				dec_first.base_source_reg = opr[W3_WB_LSB+:4];
				dec_first.second_source_reg = opr[W3_WS_LSB+:4];
				dec_first.src_mode = opr[W3_SMODE_LSB+:2];
				dec_first.dest_reg = opr[W3_WD_LSB+:4];
				dec_first.dest_mode = opr[W3_DMODE_LSB+:2];
				dec_first.dest_valid = 1'b1;
			end
			FMT_FILE: begin
				dec_first.file_reg_addr = opr[FR_F_LSB+:FR_F_W];
				dec_first.target_is_file = 1'b1;
				dec_first.dest_to_file = opr[FR_DST_BIT];
			end
			FMT_BIT: begin
				dec_first.target_is_file = opr[BT_TGT_BIT];
				if (opr[BT_TGT_BIT]) begin
					// File targets are byte wide: bit number 0..7 only
					dec_first.file_reg_addr =
						{1'b0, opr[BT_F_W-1:0]};
					dec_first.bit_pos =
						{1'b0, opr[BT_FLIT_LSB+:BT_FLIT_W]};
				end else begin
					dec_first.second_source_reg = opr[BT_WS_LSB+:4];
					dec_first.src_mode = opr[BT_MODE_LSB+:2];
					dec_first.base_source_reg = opr[BT_WB_LSB+:4];
					dec_first.bit_pos_indirect = opr[BT_IND_BIT];
					dec_first.bit_pos = opr[BT_LIT_LSB+:4];
				end
			end
			FMT_LIT_W: begin
				dec_first.literal_value =
					{4'h0, opr[LW_LIT_LSB+:LW_LIT_W]};
				dec_first.base_source_reg = opr[LW_WB_LSB+:4];
				dec_first.lit_valid = 1'b1;
			end
			FMT_LIT_F: begin
				dec_first.literal_value =
					{8'h00, opr[LF_LIT_LSB+:LF_LIT_W]};
				dec_first.file_reg_addr =
					{5'h00, opr[LF_F_LSB+:LF_F_W]};
				dec_first.target_is_file = 1'b1;
				dec_first.lit_valid = 1'b1;
			end
			FMT_LIT_ARITH: begin
				dec_first.base_source_reg = opr[LA_WB_LSB+:4];
				dec_first.literal_value =
					{11'h000, opr[LA_LIT_LSB+:LA_LIT_W]};
				dec_first.lit_valid = 1'b1;
				dec_first.dest_valid = opr[LA_DV_BIT];
				if (opr[LA_DV_BIT]) begin
					dec_first.dest_reg = opr[LA_WD_LSB+:4];
					dec_first.dest_mode = opr[LA_DMODE_LSB+:2];
				end else begin
					// Result returns to the first source
					dec_first.dest_reg = opr[LA_WB_LSB+:4];
				end
			end
			FMT_MAC: begin
				dec_first.acc_b = opr[MC_ACC_BIT];
				case (opr[MC_PAIR_LSB+:3])
					3'h0: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h45;
					3'h1: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h46;
					3'h2: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h47;
					3'h3: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h56;
					3'h4: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h57;
					3'h5: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h67;
					3'h6: {dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h44;
					default: begin
						{dec_first.mul_reg_x, dec_first.mul_reg_y} = 8'h55;
					end
				endcase
				dec_first.x_pf_op = opr[MC_XOP_LSB+:2];
				dec_first.x_pf_dst = MC_PF_BASE + {2'b00, opr[MC_XDST_LSB+:2]};
				dec_first.y_pf_op = opr[MC_YOP_LSB+:2];
				dec_first.y_pf_dst = MC_PF_BASE + {2'b00, opr[MC_YDST_LSB+:2]};
				dec_first.awb_dst = opr[MC_AWB_LSB+:2];
			end
			FMT_DSP: begin
				dec_first.acc_b = opr[DS_ACC_BIT];
				dec_first.dsp_reg_is_dest = opr[DS_DST_BIT];
				dec_first.dsp_reg = opr[DS_REG_LSB+:4];
				if (opr[DS_DST_BIT])
					dec_first.dest_mode = opr[DS_MODE_LSB+:2];
				else
					dec_first.src_mode = opr[DS_MODE_LSB+:2];
				dec_first.shift_used = opr[DS_SHU_BIT];
				if (opr[DS_SHU_BIT]) begin
					dec_first.shift_from_reg = opr[DS_SHR_BIT];
					if (opr[DS_SHR_BIT])
						dec_first.shift_amount_reg = opr[DS_WN_LSB+:4];
					else
						dec_first.shift_lit = opr[DS_SHL_LSB+:DS_SHL_W];
				end
			end
			FMT_CTRL: begin
				// Target or mode bits pass as a raw literal
				dec_first.literal_value = opr;
				dec_first.lit_valid = 1'b1;
			end
			// A lone second word has a zero opcode and does nothing
			default: begin
				dec_first.fmt = FMT_NOP;
			end
		endcase
	end

	// ****************************************************************
	// Word gathering and output holding
	// ****************************************************************
	// Only one result register: a held result stalls the fetch side
	assign word_ready = !valid_reg || dec_ready;
	assign accept = word_valid && word_ready;
	assign dec_out = out_reg;
	assign dec_valid = valid_reg;

	always_comb begin
		state_next = state_reg;
		pend_next = pend_reg;
		out_next = out_reg;
		valid_next = valid_reg;
		if (valid_reg && dec_ready)
			valid_next = 1'b0;
		case (state_reg)
			ST_FIRST: begin
				if (accept && two_word_w) begin
					pend_next = dec_first;
					state_next = ST_SECOND;
				end else if (accept) begin
					out_next = dec_first;
					valid_next = 1'b1;
				end
			end
			ST_SECOND: begin
				if (accept) begin
					out_next = pend_reg;
					out_next.ext_word = opr;
					// Upper byte must be zero; flagged but still consumed
					out_next.second_bad = |opcode;
					valid_next = 1'b1;
					state_next = ST_FIRST;
				end
			end
			default: begin
				state_next = ST_FIRST;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_FIRST;
			pend_reg <= '0;
			out_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			out_reg <= out_next;
			valid_reg <= valid_next;
		end
	end

endmodule : ifd_decoder

// *** src/ifd_pkg.sv ***
package ifd_pkg;

	// ****************************************************************
	// Word layout
	// ****************************************************************
	localparam int WORD_W = 24;
	localparam int OPC_MSB = 23;
	localparam int OPC_LSB = 16;
	localparam int OPR_W = 16;
	localparam logic [7:0] OPC_NOP = 8'h00;

	// Default codes of the three two-word control instructions
	localparam logic [7:0] TW_OPC0 = 8'h02;
	localparam logic [7:0] TW_OPC1 = 8'h04;
	localparam logic [7:0] TW_OPC2 = 8'h07;

	// ****************************************************************
	// Opcode groups (upper nibble of the opcode)
	// ****************************************************************
	localparam logic [3:0] GRP_CTRL = 4'h0;
	localparam logic [3:0] GRP_LIT_ARITH = 4'h6;
	localparam logic [3:0] GRP_LIT_W = 4'h8;
	localparam logic [3:0] GRP_LIT_F = 4'h9;
	localparam logic [3:0] GRP_BIT = 4'hA;
	localparam logic [3:0] GRP_FILE = 4'hB;
	localparam logic [3:0] GRP_MAC = 4'hC;
	localparam logic [3:0] GRP_DSP = 4'hF;

	// ****************************************************************
	// Operand field positions within bits 15:0
	// ****************************************************************
	// Three-operand working register form
	localparam int W3_WB_LSB = 12, W3_DMODE_LSB = 10, W3_WD_LSB = 6;
	localparam int W3_SMODE_LSB = 4, W3_WS_LSB = 0;
	// File register form
	localparam int FR_DST_BIT = 15, FR_F_LSB = 0, FR_F_W = 13;
	// Bit form
	localparam int BT_TGT_BIT = 15, BT_IND_BIT = 14, BT_MODE_LSB = 12;
	localparam int BT_WS_LSB = 8, BT_WB_LSB = 4, BT_LIT_LSB = 0;
	localparam int BT_FLIT_LSB = 12, BT_FLIT_W = 3, BT_F_W = 12;
	// Literal move forms
	localparam int LW_LIT_LSB = 4, LW_LIT_W = 12, LW_WB_LSB = 0;
	localparam int LF_LIT_LSB = 8, LF_LIT_W = 8, LF_F_LSB = 0;
	localparam int LF_F_W = 8;
	// Literal arithmetic form
	localparam int LA_LIT_LSB = 11, LA_LIT_W = 5, LA_DV_BIT = 10;
	localparam int LA_DMODE_LSB = 8, LA_WD_LSB = 4, LA_WB_LSB = 0;
	// Multiply-accumulate form
	localparam int MC_ACC_BIT = 15, MC_PAIR_LSB = 12, MC_XOP_LSB = 10;
	localparam int MC_XDST_LSB = 8, MC_YOP_LSB = 6, MC_YDST_LSB = 4;
	localparam int MC_AWB_LSB = 2;
	localparam logic [3:0] MC_PF_BASE = 4'h4;
	// Non-multiplying DSP form
	localparam int DS_ACC_BIT = 15, DS_DST_BIT = 14, DS_MODE_LSB = 12;
	localparam int DS_REG_LSB = 8, DS_SHU_BIT = 7, DS_SHR_BIT = 6;
	localparam int DS_SHL_LSB = 0, DS_SHL_W = 6, DS_WN_LSB = 0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		CLS_WORD_BYTE, CLS_BIT, CLS_LITERAL, CLS_DSP, CLS_CONTROL
	} ifd_class_t;

	typedef enum logic [3:0] {
		FMT_NOP, FMT_CTRL, FMT_WREG3, FMT_FILE, FMT_BIT, FMT_LIT_W,
		FMT_LIT_F, FMT_LIT_ARITH, FMT_MAC, FMT_DSP
	} ifd_fmt_t;

	// Address modifier: direct, indirect, post-increment, pre-decrement
	typedef logic [1:0] ifd_amode_t;

	typedef struct packed {
		ifd_class_t  cls;
		ifd_fmt_t    fmt;
		logic        two_word;
		logic        second_bad;
		logic [3:0]  base_source_reg;
		logic [3:0]  second_source_reg;
		ifd_amode_t  src_mode;
		logic [3:0]  dest_reg;
		ifd_amode_t  dest_mode;
		logic        dest_valid;
		logic [12:0] file_reg_addr;
		logic        target_is_file;
		logic        dest_to_file;
		logic [3:0]  bit_pos;
		logic        bit_pos_indirect;
		logic [15:0] literal_value;
		logic        lit_valid;
		logic        acc_b;
		logic [3:0]  mul_reg_x;
		logic [3:0]  mul_reg_y;
		logic [1:0]  x_pf_op;
		logic [3:0]  x_pf_dst;
		logic [1:0]  y_pf_op;
		logic [3:0]  y_pf_dst;
		logic [1:0]  awb_dst;
		logic [3:0]  dsp_reg;
		logic        dsp_reg_is_dest;
		logic        shift_used;
		logic        shift_from_reg;
		logic [3:0]  shift_amount_reg;
		logic [5:0]  shift_lit;
		logic [15:0] ext_word;
	} ifd_dec_t;

endpackage : ifd_pkg

// *** src/ifd_classify.sv ***
`timescale 1ns/1ns

// Maps an opcode onto its class, operand layout and length
module ifd_classify import ifd_pkg::*; #(
	parameter logic [7:0] TWO_WORD_A = TW_OPC0,
	parameter logic [7:0] TWO_WORD_B = TW_OPC1,
	parameter logic [7:0] TWO_WORD_C = TW_OPC2
) (
	input  wire logic [7:0] opcode,
	output ifd_class_t      cls,
	output ifd_fmt_t        fmt,
	output logic            two_word
);

	// ****************************************************************
	// Group lookup
	// ****************************************************************
	always_comb begin
		two_word = 1'b0;
		case (opcode[7:4])
			GRP_CTRL: begin
				cls = CLS_CONTROL;
				fmt = (opcode == OPC_NOP) ? FMT_NOP : FMT_CTRL;
				two_word = (opcode == TWO_WORD_A) ||
					(opcode == TWO_WORD_B) ||
					(opcode == TWO_WORD_C);
			end
			GRP_LIT_ARITH: begin
				cls = CLS_LITERAL;
				fmt = FMT_LIT_ARITH;
			end
			GRP_LIT_W: begin
				cls = CLS_LITERAL;
				fmt = FMT_LIT_W;
			end
			GRP_LIT_F: begin
				cls = CLS_LITERAL;
				fmt = FMT_LIT_F;
			end
			GRP_BIT: begin
				cls = CLS_BIT;
				fmt = FMT_BIT;
			end
			GRP_FILE: begin
				cls = CLS_WORD_BYTE;
				fmt = FMT_FILE;
			end
			GRP_MAC: begin
				cls = CLS_DSP;
				fmt = FMT_MAC;
			end
			GRP_DSP: begin
				cls = CLS_DSP;
				fmt = FMT_DSP;
			end
			// Every remaining group is a three-operand register op
			default: begin
				cls = CLS_WORD_BYTE;
				fmt = FMT_WREG3;
			end
		endcase
	end

endmodule : ifd_classify

// *** tb/ifd_asserts.sv ***
`timescale 1ns/1ns

// ****************************************************************
// Handshake and decode checker
// ****************************************************************
module ifd_asserts import ifd_pkg::*; #(
	parameter logic [7:0] TWO_WORD_A = TW_OPC0,
	parameter logic [7:0] TWO_WORD_B = TW_OPC1,
	parameter logic [7:0] TWO_WORD_C = TW_OPC2
) (
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic [WORD_W-1:0] instr_word,
	input wire logic              word_valid,
	input wire logic              word_ready,
	input wire ifd_dec_t          dec_out,
	input wire logic              dec_valid,
	input wire logic              dec_ready
);
	logic              take;
	logic              is_tw;
	logic              pend_reg;
	logic              pend_next;
	logic [WORD_W-1:0] word_q_reg;
	logic [WORD_W-1:0] word_q_next;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// A first word of a two-word op leaves the next take as its tail
	assign take = word_valid && word_ready;
	assign is_tw = instr_word[OPC_MSB:OPC_LSB] inside
		{TWO_WORD_A, TWO_WORD_B, TWO_WORD_C};
	always_comb begin
		pend_next = take ? (!pend_reg && is_tw) : pend_reg;
		word_q_next = instr_word;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
			word_q_reg <= 24'h00_0000;
		end else begin
			pend_reg <= pend_next;
			word_q_reg <= word_q_next;
		end
	end

	ready_rule_a: assert property (word_ready == (!dec_valid || dec_ready))
		else $error("word_ready disagrees with result state");
	stall_hold_a: assert property (dec_valid && !dec_ready |=>
		dec_valid && $stable(dec_out)) else $error("result moved in stall");
	no_spurious_a: assert property (!take && !(dec_valid && !dec_ready)
		|=> !dec_valid) else $error("result without a taken word");
	one_word_a: assert property (take && !pend_reg && !is_tw |=>
		dec_valid && !dec_out.two_word) else $error("single word late");
	first_word_a: assert property (take && !pend_reg && is_tw |=>
		!dec_valid) else $error("two-word op done after one word");
	second_word_a: assert property (take && pend_reg |=> dec_valid &&
		dec_out.two_word && dec_out.ext_word == word_q_reg[OPR_W-1:0])
		else $error("second word not gathered");
	bad_tail_a: assert property (take && pend_reg |=> dec_out.second_bad
		== (word_q_reg[OPC_MSB:OPC_LSB] != 8'h00))
		else $error("second word flag wrong");
	lone_nop_a: assert property (take && !pend_reg &&
		instr_word[OPC_MSB:OPC_LSB] == OPC_NOP |=> dec_out.fmt == FMT_NOP
		&& dec_out.cls == CLS_CONTROL) else $error("zero opcode not nop");
	file_addr_a: assert property (take && !pend_reg &&
		instr_word[23:20] == GRP_FILE |=> dec_out.fmt == FMT_FILE &&
		dec_out.file_reg_addr == word_q_reg[12:0])
		else $error("file address wrong");
	bit_class_a: assert property (take && !pend_reg &&
		instr_word[23:20] == GRP_BIT |=> dec_out.cls == CLS_BIT)
		else $error("bit op class wrong");
endmodule : ifd_asserts

bind ifd_decoder ifd_asserts #(.TWO_WORD_A(TWO_WORD_A),
	.TWO_WORD_B(TWO_WORD_B), .TWO_WORD_C(TWO_WORD_C)) ifd_asserts_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
	.word_valid(word_valid), .word_ready(word_ready), .dec_out(dec_out),
	.dec_valid(dec_valid), .dec_ready(dec_ready));

// *** tb/ifd_sink.sv ***
`timescale 1ns/1ns

// ****************************************************************
// Datapath sink model
// ****************************************************************
// Takes results at once, or stalls at random while stall is high
module ifd_sink (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic stall,
	output logic      dec_ready
);
	// Ready moves only just after an edge so a result is never half taken
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_ready <= 1'b0;
		end else begin
			dec_ready <= !stall || ($urandom_range(2, 0) == 0);
		end
	end
endmodule : ifd_sink

// *** tb/ifd_decoder_tb.sv ***
`timescale 1ns/1ns

module ifd_decoder_tb import ifd_pkg::*;;
	logic        sys_clk;
	logic        rst_n;
	logic [23:0] instr_word;
	logic        word_valid;
	logic        word_ready;
	ifd_dec_t    dec_out;
	logic        dec_valid;
	logic        dec_ready;
	logic        stall;
	int          err_total;
	int          checks_done;
	ifd_dec_t    exp_q[$];
	ifd_dec_t    e;
	logic [7:0]  op;

	ifd_decoder ifd_decoder_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.instr_word(instr_word), .word_valid(word_valid),
		.word_ready(word_ready), .dec_out(dec_out), .dec_valid(dec_valid),
		.dec_ready(dec_ready));
	ifd_sink ifd_sink_inst (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
		.dec_ready(dec_ready));

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// Only the operands that matter for each layout are compared
	function automatic logic [63:0] pick(input ifd_dec_t d);
		logic [39:0] f;
		case (d.fmt)
			FMT_WREG3: f = 40'({d.base_source_reg, d.src_mode,
				d.second_source_reg, d.dest_mode, d.dest_reg});
			FMT_FILE: f = 40'({d.dest_to_file, d.file_reg_addr});
			FMT_BIT: f = 40'({d.target_is_file, d.bit_pos,
				d.bit_pos_indirect, d.file_reg_addr, d.src_mode,
				d.second_source_reg, d.base_source_reg});
			FMT_LIT_W: f = 40'({d.target_is_file, d.literal_value,
				d.base_source_reg});
			FMT_LIT_F: f = 40'({d.target_is_file, d.literal_value,
				d.file_reg_addr});
			FMT_LIT_ARITH: f = 40'({d.dest_valid, d.dest_reg, d.dest_mode,
				d.base_source_reg, d.literal_value});
			FMT_MAC: f = 40'({d.acc_b, d.mul_reg_x, d.mul_reg_y, d.x_pf_op,
				d.x_pf_dst, d.y_pf_op, d.y_pf_dst, d.awb_dst});
			FMT_DSP: f = 40'({d.acc_b, d.dsp_reg_is_dest, d.dsp_reg,
				d.src_mode, d.dest_mode, d.shift_used, d.shift_from_reg,
				d.shift_amount_reg, d.shift_lit});
			FMT_CTRL: f = 40'({d.second_bad, d.ext_word, d.literal_value});
			default: f = 40'h00_0000_0000;
		endcase
		return {16'h0000, d.cls, d.fmt, d.two_word, f};
	endfunction : pick

	// Expected decode of a first word w with its possible tail v
	function automatic ifd_dec_t exp_of(input logic [23:0] w, v);
		ifd_dec_t    x;
		logic [63:0] pairs;
		x = '0;
		// Multiplier registers x,y for pair codes 0..7, low byte first
		pairs = 64'h5544_6757_5647_4645;
		x.cls = CLS_WORD_BYTE;
		x.fmt = FMT_WREG3;
		case (w[23:20])
			GRP_CTRL: begin
				x.cls = CLS_CONTROL;
				x.fmt = (w[23:16] == OPC_NOP) ? FMT_NOP : FMT_CTRL;
				x.literal_value = w[15:0];
				x.two_word = w[23:16] inside {TW_OPC0, TW_OPC1, TW_OPC2};
				x.ext_word = x.two_word ? v[15:0] : 16'h0000;
				x.second_bad = x.two_word && (v[23:16] != 8'h00);
			end
			GRP_LIT_ARITH: begin
				x.cls = CLS_LITERAL;
				x.fmt = FMT_LIT_ARITH;
				x.literal_value = {11'h000, w[15:11]};
				x.dest_valid = w[10];
				x.dest_reg = w[10] ? w[7:4] : w[3:0];
				x.dest_mode = w[10] ? w[9:8] : 2'b00;
				x.base_source_reg = w[3:0];
			end
			GRP_LIT_W: begin
				x.cls = CLS_LITERAL;
				x.fmt = FMT_LIT_W;
				x.literal_value = {4'h0, w[15:4]};
				x.base_source_reg = w[3:0];
			end
			GRP_LIT_F: begin
				x.cls = CLS_LITERAL;
				x.fmt = FMT_LIT_F;
				x.target_is_file = 1'b1;
				x.literal_value = {8'h00, w[15:8]};
				x.file_reg_addr = {5'h00, w[7:0]};
			end
			GRP_BIT: begin
				x.cls = CLS_BIT;
				x.fmt = FMT_BIT;
				x.target_is_file = w[15];
				if (w[15]) begin
					x.bit_pos = {1'b0, w[14:12]};
					x.file_reg_addr = {1'b0, w[11:0]};
				end else begin
					x.bit_pos = w[3:0];
					x.bit_pos_indirect = w[14];
					x.src_mode = w[13:12];
					x.second_source_reg = w[11:8];
					x.base_source_reg = w[7:4];
				end
			end
			GRP_FILE: begin
				x.fmt = FMT_FILE;
				x.dest_to_file = w[15];
				x.file_reg_addr = w[12:0];
			end
			GRP_MAC: begin
				x.cls = CLS_DSP;
				x.fmt = FMT_MAC;
				x.acc_b = w[15];
				{x.mul_reg_x, x.mul_reg_y} = pairs[{w[14:12], 3'b000} +: 8];
				x.x_pf_op = w[11:10];
				x.x_pf_dst = MC_PF_BASE + {2'b00, w[9:8]};
				x.y_pf_op = w[7:6];
				x.y_pf_dst = MC_PF_BASE + {2'b00, w[5:4]};
				x.awb_dst = w[3:2];
			end
			GRP_DSP: begin
				x.cls = CLS_DSP;
				x.fmt = FMT_DSP;
				x.acc_b = w[15];
				x.dsp_reg_is_dest = w[14];
				x.dsp_reg = w[11:8];
				x.dest_mode = w[14] ? w[13:12] : 2'b00;
				x.src_mode = w[14] ? 2'b00 : w[13:12];
				x.shift_used = w[7];
				x.shift_from_reg = w[7] && w[6];
				x.shift_amount_reg = (w[7] && w[6]) ? w[3:0] : 4'h0;
				x.shift_lit = (w[7] && !w[6]) ? w[5:0] : 6'h00;
			end
			default: begin
				{x.base_source_reg, x.dest_mode, x.dest_reg} = w[15:6];
				{x.src_mode, x.second_source_reg} = w[5:0];
			end
		endcase
		return x;
	endfunction : exp_of

	// ****************************************************************
	// Fetch-side driver
	// ****************************************************************
	// Word and valid hold until an edge where ready was seen high
	task automatic send(input logic [23:0] w);
		int n;
		instr_word <= w;
		word_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (word_ready !== 1'b1 && n < 50);
		// A fetch side refused this long means the decoder has hung
		if (word_ready !== 1'b1) begin
			err_total++;
		end
		@(posedge sys_clk);
	endtask : send

	task automatic instr(input logic [23:0] w, v);
		send(w);
		if (w[23:16] inside {TW_OPC0, TW_OPC1, TW_OPC2}) begin
			send(v);
		end
		exp_q.push_back(exp_of(w, v));
		if ($urandom_range(3, 0) == 0) begin
			word_valid <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : instr

	// Result monitor; a taken result is compared by its layout
	always @(posedge sys_clk) begin
		if (rst_n === 1'b1 && dec_valid === 1'b1 && dec_ready === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
			case (e.fmt)
				FMT_NOP: chk(pick(dec_out), pick(e));
				FMT_CTRL: chk(pick(dec_out), pick(e));
				FMT_WREG3: chk(pick(dec_out), pick(e));
				FMT_FILE: chk(pick(dec_out), pick(e));
				FMT_BIT: chk(pick(dec_out), pick(e));
				FMT_LIT_W, FMT_LIT_F: chk(pick(dec_out), pick(e));
				FMT_LIT_ARITH: chk(pick(dec_out), pick(e));
				FMT_MAC: chk(pick(dec_out), pick(e));
				default: chk(pick(dec_out), pick(e));
			endcase
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Hang guard: the whole run needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end

	initial begin
		{rst_n, word_valid, stall, err_total, checks_done} = '0;
		instr_word = 24'h00_0000;
		void'($urandom(41));
		repeat (5) @(posedge sys_clk);
		chk(64'({dec_valid, word_ready, dec_out === '0}), 64'h3);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		// Corner cases: lone zero opcode, good and bad tails, top address
		instr(24'h00_1234, 24'h00_0000);
		instr({TW_OPC0, 16'hFFFF}, 24'h00_BEEF);
		instr({TW_OPC2, 16'h0001}, 24'h5A_0002);
		instr(24'hB0_9FFF, 24'h00_0000);
		stall <= 1'b1;
		for (int i = 0; i < 400; i++) begin
			op = 8'($urandom);
			if ($urandom_range(4, 0) == 0) begin
				op = (i % 3 == 0) ? TW_OPC0 : ((i % 3 == 1) ? TW_OPC1 : TW_OPC2);
			end
			instr({op, 16'($urandom)},
				{($urandom_range(5, 0) == 0) ? 8'($urandom) : 8'h00, 16'($urandom)});
		end
		word_valid <= 1'b0;
		stall <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(64'(exp_q.size()), 64'h0);
		end_sim();
	end
endmodule : ifd_decoder_tb
